/* File: hdl/flag_exec_defines.vh */
// constants for the status-flag and bit-transfer instruction executor
// Notes on behaviour
// RULE1: bit-load copies the transfer flag into the chosen bit of the destination register, flags unchanged, one cycle.
// RULE2: set-overflow makes the overflow flag one and touches no other flag, one cycle.
// RULE3: clear-overflow makes the overflow flag zero and touches no other flag, one cycle.
// RULE4: set-half-carry makes the half carry flag one and touches no other flag, one cycle.
// RULE5: clear-half-carry makes the half carry flag zero and touches no other flag, one cycle.
// RULE6: interrupt-enable makes the global interrupt enable flag one and nothing else, one cycle.
// RULE7: interrupt-disable makes the global interrupt enable flag zero and nothing else, one cycle.
// RULE8: set-sign makes the signed test flag one and leaves the others, one cycle.
// RULE9: clear-sign makes the signed test flag zero and leaves the others, one cycle.
// RULE10: sleep takes one cycle, changes no flag and asks the power-saving logic to sleep.
// RULE11: watchdog-restart takes one cycle, changes no flag and tells the watchdog to restart.
// RULE12: set and clear of carry, zero, negative and transfer each force only their own flag, one cycle.
// RULE13: no-operation takes one cycle and changes nothing except advancing the program counter.
// RULE14: bit-store copies the chosen bit of a source register into the transfer flag, one cycle.
`ifndef FLAG_EXEC_DEFINES_VH
`define FLAG_EXEC_DEFINES_VH

// ==========================================================
// instruction word layout
`define OP_CLASS_HI     15
`define OP_CLASS_LO     12
`define OP_REG_HI       8
`define OP_REG_LO       4
`define OP_SEL_HI       2
`define OP_SEL_LO       0

// ==========================================================
// instruction classes
`define CLS_NOP         4'h0
`define CLS_FLAG_SET    4'h1
`define CLS_FLAG_CLEAR  4'h2
`define CLS_BIT_LOAD    4'h3
`define CLS_BIT_STORE   4'h4
`define CLS_SLEEP       4'h5
`define CLS_WDT_RESTART 4'h6

// ==========================================================
// status register bit positions
`define FLAG_CARRY      3'h0
`define FLAG_ZERO       3'h1
`define FLAG_NEGATIVE   3'h2
`define FLAG_OVERFLOW   3'h3
`define FLAG_SIGN       3'h4
`define FLAG_HALF_CARRY 3'h5
`define FLAG_TRANSFER   3'h6
`define FLAG_IRQ_ENABLE 3'h7

// ==========================================================
// reset values
`define STATUS_RESET    8'h00
`define GPR_RESET       8'h00

`endif

/* File: hdl/gpr_file.v */
// general register file, one write port and one registered read port
`timescale 1ns/10ps
`default_nettype none

module gpr_file #(
  parameter ADDR_W = 5,
  parameter DATA_W = 8
) (
  input  wire              sys_clk,
  input  wire              wr_en,
  input  wire [ADDR_W-1:0] wr_addr,
  input  wire [DATA_W-1:0] wr_data,
  input  wire [ADDR_W-1:0] rd_addr,
  output reg  [DATA_W-1:0] rd_data_reg
);

  reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // ==========================================================
  // write-first bypass lets back-to-back read-modify-write on one register see fresh data
  always @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (wr_en && (wr_addr == rd_addr)) begin
      rd_data_reg <= wr_data;
    end else begin
      rd_data_reg <= mem[rd_addr];
    end
  end

endmodule // gpr_file

`default_nettype wire

/* File: hdl/status_flag_instr_exec.v */
// decoder and executor for flag set/clear, bit transfer, no-op, sleep and watchdog restart
`timescale 1ns/10ps
`default_nettype none
`include "flag_exec_defines.vh"

module status_flag_instr_exec #(
  parameter ADDR_W = 5,
  parameter DATA_W = 8
) (
  input  wire              sys_clk,
  input  wire              rst_n,
  input  wire              instr_valid,
  input  wire [15:0]       instr_word,
  input  wire              preload_en,
  input  wire [ADDR_W-1:0] preload_addr,
  input  wire [DATA_W-1:0] preload_data,
  input  wire [ADDR_W-1:0] peek_addr,
  output wire              preload_ready,
  output wire [DATA_W-1:0] peek_data,
  output reg  [7:0]        status_register,
  output wire              global_irq_enable,
  output reg               pc_advance_reg,
  output reg               sleep_req_reg,
  output reg               watchdog_restart_reg,
  output reg               illegal_op_reg
);

  // ==========================================================
  // decode helpers
  function is_class;
    input [15:0] word;
    input [3:0]  clear_sign_op;
    begin
      is_class = (word[`OP_CLASS_HI:`OP_CLASS_LO] == clear_sign_op);
    end
  endfunction

  function is_known;
    input [15:0] word;
    begin
      is_known = is_class(word, `CLS_NOP)      | is_class(word, `CLS_FLAG_SET)
               | is_class(word, `CLS_FLAG_CLEAR) | is_class(word, `CLS_BIT_LOAD)
               | is_class(word, `CLS_BIT_STORE)  | is_class(word, `CLS_SLEEP)
               | is_class(word, `CLS_WDT_RESTART);
    end
  endfunction

  // ==========================================================
  // execute stage: the register file read takes the accept edge, so
  // each instruction acts one cycle after it is taken, one per cycle
  reg              ex_valid_reg;
  reg [15:0]       ex_word_reg;
  reg [7:0]        status_next;
  reg              gpr_wr_en;
  reg [DATA_W-1:0] gpr_wr_data;

  wire [DATA_W-1:0] gpr_rd_data;
  wire [2:0]        ex_sel  = ex_word_reg[`OP_SEL_HI:`OP_SEL_LO];
  wire [ADDR_W-1:0] ex_reg  = ex_word_reg[`OP_REG_LO+ADDR_W-1:`OP_REG_LO];
  wire [ADDR_W-1:0] rd_addr = instr_valid ?
                              instr_word[`OP_REG_LO+ADDR_W-1:`OP_REG_LO] : peek_addr;

  wire do_set    = ex_valid_reg && is_class(ex_word_reg, `CLS_FLAG_SET);
  wire do_clear  = ex_valid_reg && is_class(ex_word_reg, `CLS_FLAG_CLEAR);
  wire do_load   = ex_valid_reg && is_class(ex_word_reg, `CLS_BIT_LOAD);
  wire do_store  = ex_valid_reg && is_class(ex_word_reg, `CLS_BIT_STORE);

  // the executing bit-load owns the write port; a preload waits a cycle
  assign preload_ready     = !do_load;
  assign peek_data         = gpr_rd_data;
  assign global_irq_enable = status_register[`FLAG_IRQ_ENABLE];

  always @* begin
    status_next = status_register;
    gpr_wr_en   = 1'b0;
    gpr_wr_data = gpr_rd_data;
    if (do_set) begin
      // one flag forced high, the rest kept
      status_next[ex_sel] = 1'b1; // RULE2 RULE4 RULE6 RULE8 RULE12
    end else if (do_clear) begin
      status_next[ex_sel] = 1'b0; // RULE3 RULE5 RULE7 RULE9 RULE12
    end else if (do_store) begin
      status_next[`FLAG_TRANSFER] = gpr_rd_data[ex_sel]; // RULE14
    end
    if (do_load) begin
      gpr_wr_en           = 1'b1;
      gpr_wr_data[ex_sel] = status_register[`FLAG_TRANSFER]; // RULE1
    end else if (preload_en) begin
      gpr_wr_en   = 1'b1;
      gpr_wr_data = preload_data;
    end
  end

  gpr_file #(
    .ADDR_W (ADDR_W),
    .DATA_W (DATA_W)
  ) u_gpr (
    .sys_clk     (sys_clk),
    .wr_en       (gpr_wr_en),
    .wr_addr     (do_load ? ex_reg : preload_addr),
    .wr_data     (gpr_wr_data),
    .rd_addr     (rd_addr),
    .rd_data_reg (gpr_rd_data)
  );

  // ==========================================================
  // sequential state
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      ex_valid_reg         <= 1'b0;
      ex_word_reg          <= 16'h0000;
      status_register      <= `STATUS_RESET;
      pc_advance_reg       <= 1'b0;
      sleep_req_reg        <= 1'b0;
      watchdog_restart_reg <= 1'b0;
      illegal_op_reg       <= 1'b0;
    end else begin
      ex_valid_reg    <= instr_valid;
      ex_word_reg     <= instr_valid ? instr_word : 16'h0000;
      // no-op, sleep and watchdog restart leave the flags as they are
      status_register <= status_next; // RULE10 RULE11 RULE13
      // every known instruction retires in its one execute cycle
      pc_advance_reg  <= ex_valid_reg && is_known(ex_word_reg); // RULE13
      sleep_req_reg   <= ex_valid_reg && is_class(ex_word_reg, `CLS_SLEEP); // RULE10
      watchdog_restart_reg <= ex_valid_reg
                              && is_class(ex_word_reg, `CLS_WDT_RESTART); // RULE11
      // unknown classes are flagged, change no flag and do not advance the program counter
      illegal_op_reg  <= ex_valid_reg && !is_known(ex_word_reg);
    end
  end

endmodule // status_flag_instr_exec

`default_nettype wire

/* File: testbench/flag_exec_assertions.sv */
// concurrent checks on the ports of the flag and bit-transfer executor
`timescale 1ns/10ps
`default_nettype none
module flag_exec_checker (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [7:0]  status_register,
  input wire logic        global_irq_enable,
  input wire logic        pc_advance_reg,
  input wire logic        sleep_req_reg,
  input wire logic        watchdog_restart_reg,
  input wire logic        illegal_op_reg
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire logic [3:0] clear_sign_op = instr_word[15:12];
  wire logic [7:0] hot = 8'h01 << instr_word[2:0];
  // flags are written at the first edge after the instruction is taken and checked at the second
  chk_flag_set: assert property (instr_valid && clear_sign_op == 4'h1 |=> ##1
    status_register == ($past(status_register) | $past(hot, 2))) else $error("flag set wrong");
  chk_flag_clear: assert property (instr_valid && clear_sign_op == 4'h2 |=> ##1
    status_register == ($past(status_register) & ~$past(hot, 2))) else $error("flag clear wrong");
  chk_flags_kept: assert property (instr_valid && (clear_sign_op == 4'h0 || clear_sign_op == 4'h3 || clear_sign_op > 4'h4)
    |=> ##1 $stable(status_register)) else $error("flags changed");
  chk_store_only_t: assert property (instr_valid && clear_sign_op == 4'h4 |=> ##1
    (status_register & 8'hbf) == ($past(status_register) & 8'hbf)) else $error("store hit flags");
  chk_sleep_pulse: assert property (instr_valid && clear_sign_op == 4'h5 |=> ##1 sleep_req_reg)
    else $error("no sleep request");
  chk_sleep_cause: assert property (sleep_req_reg |-> $past(instr_valid && clear_sign_op == 4'h5, 2))
    else $error("stray sleep request");
  chk_wdt_pulse: assert property (instr_valid && clear_sign_op == 4'h6 |=> ##1 watchdog_restart_reg)
    else $error("no watchdog restart");
  chk_pc_step: assert property (instr_valid && clear_sign_op < 4'h7 |=> ##1 pc_advance_reg && !illegal_op_reg)
    else $error("no pc advance");
  chk_irq_mirror: assert property (global_irq_enable == status_register[7])
    else $error("irq enable differs");
endmodule // flag_exec_checker
bind status_flag_instr_exec flag_exec_checker flag_exec_checker_inst (.sys_clk, .rst_n,
  .instr_valid, .instr_word, .status_register, .global_irq_enable, .pc_advance_reg,
  .sleep_req_reg, .watchdog_restart_reg, .illegal_op_reg);
`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking bench for the flag and bit-transfer executor
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        sys_clk = 1'b0, rst_n = 1'b0, instr_valid = 1'b0, preload_en = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic [4:0]  preload_addr = 5'h00, peek_addr = 5'h00;
  logic [7:0]  preload_data = 8'h00, peek_data, status_register, st_m = 8'h00, regs_m [0:31];
  logic        preload_ready, global_irq_enable, pc_advance_reg, sleep_req_reg;
  logic        watchdog_restart_reg, illegal_op_reg;
  logic [31:0] r;
  integer      fails = 0, checks = 0, i, seed = 32'h99da5a4a;
  status_flag_instr_exec status_flag_instr_exec_inst (.sys_clk, .rst_n, .instr_valid,
    .instr_word, .preload_en, .preload_addr, .preload_data, .peek_addr, .preload_ready,
    .peek_data, .status_register, .global_irq_enable, .pc_advance_reg, .sleep_req_reg,
    .watchdog_restart_reg, .illegal_op_reg);
  initial forever #5 sys_clk = ~sys_clk;
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (fails == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ==========================================================
  // one instruction, model updated, flags then pulses compared
  task automatic exec(input logic [15:0] w);
    logic [3:0] c;
    c = w[15:12];
    instr_valid = 1'b1;
    instr_word = w;
    @(negedge sys_clk);
    instr_valid = 1'b0;
    peek_addr = w[8:4];
    case (c)
      4'h1: st_m[w[2:0]] = 1'b1;
      4'h2: st_m[w[2:0]] = 1'b0;
      4'h3: regs_m[w[8:4]][w[2:0]] = st_m[6];
      4'h4: st_m[6] = regs_m[w[8:4]][w[2:0]];
      default: ;
    endcase
    // the bit-load owns the write port in its execute cycle
    cmp({7'h00, preload_ready}, {7'h00, c != 4'h3});
    @(negedge sys_clk);
    cmp(status_register, st_m);
    cmp(peek_data, regs_m[w[8:4]]);
    cmp({4'h0, pc_advance_reg, sleep_req_reg, watchdog_restart_reg, illegal_op_reg},
        {4'h0, c < 4'h7, c == 4'h5, c == 4'h6, c > 4'h6});
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (6) @(negedge sys_clk);
    rst_n = 1'b1;
    cmp(status_register, 8'h00);
    // register contents are not reset, so every one is preloaded
    for (i = 0; i < 32; i++) begin
      r = $random(seed);
      preload_en = 1'b1;
      preload_addr = i[4:0];
      preload_data = r[7:0];
      regs_m[i] = r[7:0];
      @(negedge sys_clk);
    end
    preload_en = 1'b0;
    for (i = 0; i < 32; i++) exec({2'b00, i[3], ~i[3], 9'h000, i[2:0]});
    for (i = 0; i < 400; i++) begin
      r = $random(seed);
      exec({r[15:12], 3'h0, r[8:4], 1'b0, r[2:0]});
    end
    rst_n = 1'b0;
    @(negedge sys_clk);
    rst_n = 1'b1;
    cmp(status_register, 8'h00);
    tally_and_finish;
  end
endmodule // testbench
`default_nettype wire
